/* File: rxcd_decoder.sv */
`timescale 1ns/100ps
`include "rxcd_consts.svh"
module rxcd_decoder (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  sck,
  input  wire logic                  sdi,
  input  wire logic                  sel_n,
  input  wire logic                  strength_above_threshold,
  input  wire logic                  quality_detect,
  input  wire logic                  clock_lock,
  input  wire logic                  wake_timer_on,
  input  wire logic                  measure_done,
  input  wire rxcd_pkg::rxcd_offset_t measured_error,
  output logic [11:0]                synth_freq,
  output logic                       valid_signal_flag,
  output logic [1:0]                 lna_gain,
  output logic [2:0]                 rssi_threshold,
  output logic                       rx_enable,
  output logic [13:0]                period_mantissa,
  output logic [3:0]                 period_exponent,
  output logic [1:0]                 period_shift,
  output logic                       wake_irq,
  output logic [3:0]                 supply_threshold_code,
  output logic                       slow_clock_out_on,
  output logic [2:0]                 host_clk_div,
  output logic                       afc_enable,
  output logic                       offset_out_enable,
  output logic                       precise_measure_mode,
  output rxcd_pkg::rxcd_offset_t     freq_offset,
  output logic                       auto_lock,
  output logic                       lock_speed_select,
  output logic                       no_autosleep,
  output logic                       filter_kind_select,
  output logic                       wake_on_any,
  output logic [2:0]                 quality_threshold,
  output logic                       rate_prescale,
  output logic [6:0]                 rate_divider
);
  import rxcd_pkg::*;

  localparam int TICK_MS = `RXCD_TICK_MS;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] sck_s_r;
  logic [1:0] sdi_s_r;
  logic [1:0] sel_s_r;
  logic [1:0] valid_src_s_r [0:2];
  logic [1:0] wake_on_s_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sck_s_r     <= 3'h0;
      sdi_s_r     <= 2'h0;
      sel_s_r     <= 2'h3;
      wake_on_s_r <= 2'h0;
      for (int i = 0; i < 3; i++) valid_src_s_r[i] <= 2'h0;
    end else begin
      sck_s_r     <= {sck_s_r[1:0], sck};
      sdi_s_r     <= {sdi_s_r[0], sdi};
      sel_s_r     <= {sel_s_r[0], sel_n};
      wake_on_s_r <= {wake_on_s_r[0], wake_timer_on};
      valid_src_s_r[0] <= {valid_src_s_r[0][0], strength_above_threshold};
      valid_src_s_r[1] <= {valid_src_s_r[1][0], quality_detect};
      valid_src_s_r[2] <= {valid_src_s_r[2][0], clock_lock};
    end
  end

  wire sck_rise = sck_s_r[1] & ~sck_s_r[2];

  // ****************************************
  // Serial shifter
  // ****************************************
  logic [15:0] shift_r;
  logic [4:0]  bit_cnt_r;
  logic        cmd_stb_r;
  logic [15:0] cmd_r;

  always_ff @(posedge clk) begin
    if (!reset_n || sel_s_r[1]) begin
      shift_r   <= 16'h0000;
      bit_cnt_r <= 5'd0;
      cmd_stb_r <= 1'b0;
      cmd_r     <= 16'h0000;
    end else begin
      cmd_stb_r <= 1'b0;
      if (sck_rise) begin
        shift_r <= {shift_r[14:0], sdi_s_r[1]};
        if (bit_cnt_r == `RXCD_CMD_BITS - 5'd1) begin
          cmd_r     <= {shift_r[14:0], sdi_s_r[1]};
          cmd_stb_r <= 1'b1;
          bit_cnt_r <= 5'd0;
        end else begin
          bit_cnt_r <= bit_cnt_r + 5'd1;
        end
      end
    end
  end

  // ****************************************
  // Command registers
  // ****************************************
  logic [15:0] rxset_r, wakec_r, wakef_r, supclk_r, afc_r, filt_r, rate_r;
  logic [11:0] freq_r;

  function automatic logic hit8(input logic [15:0] c, input logic [7:0] code);
    hit8 = (c[15:8] == code);
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      freq_r   <= 12'(`RXCD_FREQ_RST);
      rxset_r  <= `RXCD_RXSET_RST;
      wakec_r  <= `RXCD_WAKEC_RST;
      wakef_r  <= `RXCD_WAKEF_RST;
      supclk_r <= `RXCD_SUPCLK_RST;
      afc_r    <= `RXCD_AFC_RST;
      filt_r   <= `RXCD_FILT_RST;
      rate_r   <= `RXCD_RATE_RST;
    end else if (cmd_stb_r) begin
      if (cmd_r[15:12] == `RXCD_FREQ_CODE &&
          cmd_r[11:0] >= `RXCD_FREQ_MIN && cmd_r[11:0] <= `RXCD_FREQ_MAX)
        freq_r <= cmd_r[11:0];
      if (cmd_r[15:12] == `RXCD_WAKEC_CODE) wakec_r <= cmd_r;
      if (hit8(cmd_r, `RXCD_WAKEF_CODE))    wakef_r <= cmd_r;
      if (hit8(cmd_r, `RXCD_RXSET_CODE))    rxset_r <= cmd_r;
      if (hit8(cmd_r, `RXCD_SUPCLK_CODE))   supclk_r <= cmd_r;
      if (hit8(cmd_r, `RXCD_AFC_CODE))      afc_r <= cmd_r;
      if (hit8(cmd_r, `RXCD_FILT_CODE))     filt_r <= cmd_r;
      if (hit8(cmd_r, `RXCD_RATE_CODE))     rate_r <= cmd_r;
    end
  end

  // ****************************************
  // Valid flag selection
  // ****************************************
  logic valid_r;
  always_ff @(posedge clk) begin
    if (!reset_n) valid_r <= 1'b0;
    else begin
      case (rxset_r[`RXCD_VSRC_HI:`RXCD_VSRC_LO])
        2'b00:   valid_r <= valid_src_s_r[0][1];
        2'b01:   valid_r <= valid_src_s_r[1][1];
        2'b10:   valid_r <= valid_src_s_r[2][1];
        default: valid_r <= 1'b1;
      endcase
    end
  end

  // ****************************************
  // Wake-up timer
  // ****************************************
  logic [16:0] tick_cnt_r;
  logic [35:0] wake_cnt_r;
  logic        wake_irq_r;
  wire  [13:0] mant = {wakef_r[5:0], wakec_r[7:0]};
  wire  [4:0]  wexp = {1'b0, wakec_r[11:8]} - {3'b000, wakef_r[7:6]};
  wire  [35:0] wake_ticks = wexp[4] ? 36'({22'h0, mant} >> (~wexp + 5'd1))
                                    : 36'({22'h0, mant} << wexp);

  always_ff @(posedge clk) begin
    if (!reset_n || !wake_on_s_r[1]) begin
      tick_cnt_r <= 17'd0;
      wake_cnt_r <= 36'h0;
      wake_irq_r <= 1'b0;
    end else begin
      wake_irq_r <= 1'b0;
      if (tick_cnt_r == 17'(TICK_MS - 1)) begin
        tick_cnt_r <= 17'd0;
        if (wake_cnt_r + 36'h1 >= wake_ticks) begin
          wake_cnt_r <= 36'h0;
          wake_irq_r <= 1'b1;
        end else wake_cnt_r <= wake_cnt_r + 36'h1;
      end else tick_cnt_r <= tick_cnt_r + 17'd1;
    end
  end

  // ****************************************
  // Frequency correction
  // ****************************************
  rxcd_afc_e mode;
  always_comb begin
    case (afc_r[7:6])
      2'b00:   mode = RXCD_AFC_MANUAL;
      2'b01:   mode = RXCD_AFC_ONCE;
      2'b10:   mode = RXCD_AFC_VALID;
      default: mode = RXCD_AFC_KEEP;
    endcase
  end

  function automatic rxcd_offset_t clamp(input rxcd_offset_t v, input logic [1:0] sel);
    logic signed [6:0] lim;
    lim = 7'sd0;
    case (sel)
      2'b01:   lim = 7'sd4;
      2'b10:   lim = 7'sd2;
      2'b11:   lim = 7'sd1;
      default: lim = 7'sd0;
    endcase
    if (sel == 2'b00) clamp = v;
    else if ($signed(v) > lim) clamp = lim;
    else if ($signed(v) < -lim) clamp = -lim;
    else clamp = v;
  endfunction

  logic         strobe_d_r, valid_d_r, valid_all_r, once_done_r;
  rxcd_offset_t last_err_r, prev_err_r, offset_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strobe_d_r  <= 1'b0;
      valid_d_r   <= 1'b0;
      valid_all_r <= 1'b1;
      once_done_r <= 1'b0;
      last_err_r  <= 7'h00;
      prev_err_r  <= 7'h00;
      offset_r    <= 7'h00;
    end else begin
      strobe_d_r <= afc_r[`RXCD_AFC_STROBE];
      valid_d_r  <= valid_r;
      if (measure_done && afc_r[`RXCD_AFC_EN]) begin
        last_err_r  <= measured_error;
        prev_err_r  <= last_err_r;
        valid_all_r <= 1'b1;
        if (mode != RXCD_AFC_MANUAL && valid_all_r && valid_r &&
            measured_error == last_err_r &&
            !(mode == RXCD_AFC_ONCE && once_done_r)) begin
          offset_r    <= clamp(measured_error, afc_r[5:4]);
          once_done_r <= 1'b1;
        end
      end else if (!valid_r) valid_all_r <= 1'b0;
      if (mode == RXCD_AFC_MANUAL && afc_r[`RXCD_AFC_STROBE] && !strobe_d_r)
        offset_r <= clamp(last_err_r, afc_r[5:4]);
      if (mode == RXCD_AFC_VALID && valid_d_r && !valid_r)
        offset_r <= 7'h00;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      synth_freq <= 12'h000;
      valid_signal_flag <= 1'b0;
      lna_gain <= 2'h0;
      rssi_threshold <= 3'h0;
      rx_enable <= 1'b0;
      period_mantissa <= 14'h0;
      period_exponent <= 4'h0;
      period_shift <= 2'h0;
      wake_irq <= 1'b0;
      supply_threshold_code <= 4'h0;
      slow_clock_out_on <= 1'b0;
      host_clk_div <= 3'h0;
      afc_enable <= 1'b0;
      offset_out_enable <= 1'b0;
      precise_measure_mode <= 1'b0;
      freq_offset <= 7'h00;
      auto_lock <= 1'b0;
      lock_speed_select <= 1'b0;
      no_autosleep <= 1'b0;
      filter_kind_select <= 1'b0;
      wake_on_any <= 1'b0;
      quality_threshold <= 3'h0;
      rate_prescale <= 1'b0;
      rate_divider <= 7'h00;
    end else begin
      synth_freq <= freq_r;
      valid_signal_flag <= valid_r;
      lna_gain <= rxset_r[5:4];
      rssi_threshold <= rxset_r[3:1];
      rx_enable <= rxset_r[`RXCD_RX_EN];
      period_mantissa <= mant;
      period_exponent <= wakec_r[11:8];
      period_shift <= wakef_r[7:6];
      wake_irq <= wake_irq_r;
      supply_threshold_code <= supclk_r[3:0];
      slow_clock_out_on <= supclk_r[`RXCD_SLOW_CLK];
      host_clk_div <= supclk_r[7:5];
      afc_enable <= afc_r[`RXCD_AFC_EN];
      offset_out_enable <= afc_r[`RXCD_AFC_OE];
      precise_measure_mode <= afc_r[`RXCD_AFC_FINE];
      freq_offset <= afc_r[`RXCD_AFC_OE] ? offset_r : 7'h00;
      auto_lock <= filt_r[`RXCD_AUTO_LOCK];
      lock_speed_select <= filt_r[`RXCD_LOCK_FAST];
      no_autosleep <= filt_r[`RXCD_NO_AUTOSLEEP];
      wake_on_any <= filt_r[`RXCD_WAKE_ANY];
      filter_kind_select <= filt_r[`RXCD_FILT_KIND];
      quality_threshold <= filt_r[2:0];
      rate_prescale <= rate_r[`RXCD_PRESCALE];
      rate_divider <= rate_r[6:0];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_freq_range: assert property (@(posedge clk) disable iff (!reset_n)
    (synth_freq >= `RXCD_FREQ_MIN && synth_freq <= `RXCD_FREQ_MAX) || $past(!reset_n))
    else $error("frequency out of range");
  a_freq_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_stb_r && cmd_r[15:12] == `RXCD_FREQ_CODE &&
     (cmd_r[11:0] < `RXCD_FREQ_MIN || cmd_r[11:0] > `RXCD_FREQ_MAX))
    |=> ##1 $stable(synth_freq))
    else $error("bad frequency stored");
  a_freq_take: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_stb_r && cmd_r[15:12] == `RXCD_FREQ_CODE &&
     cmd_r[11:0] >= `RXCD_FREQ_MIN && cmd_r[11:0] <= `RXCD_FREQ_MAX)
    |=> ##1 synth_freq == $past(cmd_r[11:0], 2))
    else $error("frequency not taken");
  a_valid_always: assert property (@(posedge clk) disable iff (!reset_n)
    (rxset_r[7:6] == 2'b11) [*2] |=> valid_signal_flag)
    else $error("valid not forced");
  a_wake_off: assert property (@(posedge clk) disable iff (!reset_n)
    !wake_on_s_r[1] [*3] |-> !wake_irq)
    else $error("wake irq while disabled");
  a_valid_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == RXCD_AFC_VALID && $fell(valid_r) && !cmd_stb_r) |=> offset_r == 7'h00)
    else $error("offset not cleared");
  a_clamp_limit: assert property (@(posedge clk) disable iff (!reset_n)
    ($past(afc_r[5:4]) == 2'b11 && $changed(offset_r)) |->
    ($signed(offset_r) <= 7'sd1 && $signed(offset_r) >= -7'sd1))
    else $error("offset clamp broken");
  a_manual_only: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == RXCD_AFC_MANUAL && $past(mode) == RXCD_AFC_MANUAL && !(afc_r[3] && !strobe_d_r))
    |=> $stable(offset_r))
    else $error("offset moved without strobe");
  a_rx_enable: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(rxset_r[0]) |=> rx_enable)
    else $error("rx enable lag");
  a_once_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == RXCD_AFC_ONCE && once_done_r) |=> $stable(offset_r))
    else $error("offset moved after single run");
  a_shift_clear: assert property (@(posedge clk) disable iff (!reset_n)
    sel_s_r[1] |=> (bit_cnt_r == 5'd0 && !cmd_stb_r))
    else $error("shifter not cleared by select");
  a_stb_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_stb_r |=> !cmd_stb_r)
    else $error("command strobe too long");
  a_oe_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !afc_r[`RXCD_AFC_OE] |=> freq_offset == 7'h00)
    else $error("offset shown while disabled");
  a_rate_take: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_stb_r && cmd_r[15:8] == `RXCD_RATE_CODE) |=> ##1 rate_divider == $past(cmd_r[6:0], 2))
    else $error("rate not taken");
  a_wake_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    wake_irq |=> !wake_irq)
    else $error("wake irq too long");
endmodule

/* File: rxcd_consts.svh */
`ifndef RXCD_CONSTS_SVH
`define RXCD_CONSTS_SVH
// ****************************************
// Command codes and defaults
// ****************************************
`define RXCD_FREQ_RST     16'hAD57
`define RXCD_RXSET_RST    16'hC080
`define RXCD_WAKEC_RST    16'hE196
`define RXCD_WAKEF_RST    16'hC300
`define RXCD_SUPCLK_RST   16'hC213
`define RXCD_AFC_RST      16'hC687
`define RXCD_FILT_RST     16'hC462
`define RXCD_RATE_RST     16'hC813
`define RXCD_FREQ_CODE    4'hA
`define RXCD_RXSET_CODE   8'hC0
`define RXCD_WAKEC_CODE   4'hE
`define RXCD_WAKEF_CODE   8'hC3
`define RXCD_SUPCLK_CODE  8'hC2
`define RXCD_AFC_CODE     8'hC6
`define RXCD_FILT_CODE    8'hC4
`define RXCD_RATE_CODE    8'hC8
`define RXCD_FREQ_MIN     12'd96
`define RXCD_FREQ_MAX     12'd3903
`define RXCD_CMD_BITS     5'd16
`define RXCD_TICK_MS      100000
// Field positions
`define RXCD_VSRC_HI      7
`define RXCD_VSRC_LO      6
`define RXCD_RX_EN        0
`define RXCD_SLOW_CLK     4
`define RXCD_AFC_EN       0
`define RXCD_AFC_OE       1
`define RXCD_AFC_FINE     2
`define RXCD_AFC_STROBE   3
`define RXCD_AUTO_LOCK    7
`define RXCD_LOCK_FAST    6
`define RXCD_NO_AUTOSLEEP 5
`define RXCD_FILT_KIND    4
`define RXCD_WAKE_ANY     3
`define RXCD_PRESCALE     7
`endif

/* File: rxcd_pkg.sv */
package rxcd_pkg;
  typedef enum logic [3:0] {
    RXCD_AFC_MANUAL = 4'b0001,
    RXCD_AFC_ONCE   = 4'b0010,
    RXCD_AFC_VALID  = 4'b0100,
    RXCD_AFC_KEEP   = 4'b1000
  } rxcd_afc_e;
  typedef logic [6:0] rxcd_offset_t;
endpackage

/* File: rxcd_host_model.sv */
`timescale 1ns/100ps
// ****************************************
// Host serial command port model
// ****************************************
module rxcd_host_model (
  input  wire logic clk,
  output logic      sck,
  output logic      sdi,
  output logic      sel_n
);
  initial begin
    sck   = 1'b0;
    sdi   = 1'b1;
    sel_n = 1'b1;
  end
  // Shifts top n bits of w, MSB first
  task automatic send(input logic [15:0] w, input int n);
    int i;
    @(negedge clk);
    sel_n = 1'b0;
    for (i = 15; i > 15 - n; i--) begin
      sdi = w[i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      sck = 1'b0;
      repeat (2) @(negedge clk);
    end
    sdi = ~sdi;
    sel_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
  import rxcd_pkg::*;
  logic                  clk, reset_n, sck, sdi, sel_n, strength_above_threshold, quality_detect;
  logic                  clock_lock, wake_timer_on, measure_done, valid_signal_flag, rx_enable, wake_irq;
  logic                  slow_clock_out_on, afc_enable, offset_out_enable, precise_measure_mode, auto_lock;
  logic                  lock_speed_select, no_autosleep, filter_kind_select, wake_on_any, rate_prescale;
  logic [11:0]           synth_freq;
  logic [13:0]           period_mantissa;
  logic [6:0]            rate_divider;
  logic [3:0]            period_exponent, supply_threshold_code;
  logic [2:0]            rssi_threshold, host_clk_div, quality_threshold;
  logic [1:0]            lna_gain, period_shift;
  rxcd_pkg::rxcd_offset_t measured_error, freq_offset;
  int                    fails, checks, i;
  logic [15:0]           fw [4] = '{16'hA060, 16'hA05F, 16'hAF3F, 16'hAF40};
  logic [15:0]           fe [4] = '{16'h0060, 16'h0060, 16'h0F3F, 16'h0F3F};
  logic [15:0]           vc [3] = '{16'hC000, 16'hC040, 16'hC080};
  // ****************************************
  // Clock, design and host
  // ****************************************
  always #5 clk = ~clk;
  rxcd_decoder dut (
    .clk                      (clk),
    .reset_n                  (reset_n),
    .sck                      (sck),
    .sdi                      (sdi),
    .sel_n                    (sel_n),
    .strength_above_threshold (strength_above_threshold),
    .quality_detect           (quality_detect),
    .clock_lock               (clock_lock),
    .wake_timer_on            (wake_timer_on),
    .measure_done             (measure_done),
    .measured_error           (measured_error),
    .synth_freq               (synth_freq),
    .valid_signal_flag        (valid_signal_flag),
    .lna_gain                 (lna_gain),
    .rssi_threshold           (rssi_threshold),
    .rx_enable                (rx_enable),
    .period_mantissa          (period_mantissa),
    .period_exponent          (period_exponent),
    .period_shift             (period_shift),
    .wake_irq                 (wake_irq),
    .supply_threshold_code    (supply_threshold_code),
    .slow_clock_out_on        (slow_clock_out_on),
    .host_clk_div             (host_clk_div),
    .afc_enable               (afc_enable),
    .offset_out_enable        (offset_out_enable),
    .precise_measure_mode     (precise_measure_mode),
    .freq_offset              (freq_offset),
    .auto_lock                (auto_lock),
    .lock_speed_select        (lock_speed_select),
    .no_autosleep             (no_autosleep),
    .filter_kind_select       (filter_kind_select),
    .wake_on_any              (wake_on_any),
    .quality_threshold        (quality_threshold),
    .rate_prescale            (rate_prescale),
    .rate_divider             (rate_divider)
  );
  rxcd_host_model u_host (
    .clk   (clk),
    .sck   (sck),
    .sdi   (sdi),
    .sel_n (sel_n)
  );
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [15:0] w);
    u_host.send(w, 16);
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic meas(input logic [6:0] v, input int k);
    repeat (k) begin
      @(negedge clk);
      measured_error = v;
      measure_done = 1'b1;
      @(negedge clk);
      measure_done = 1'b0;
      waitn(10);
    end
  endtask
  task automatic do_reset();
    @(negedge clk);
    reset_n = 1'b0;
    waitn(3);
    reset_n = 1'b1;
    waitn(4);
  endtask
  task automatic chk_def();
    chk("freq", 16'h0D57, {4'h0, synth_freq});
    chk("rx", 16'h0000, {10'h0, lna_gain, rssi_threshold, rx_enable});
    chk("vflag", 16'h0001, {15'h0, valid_signal_flag});
    chk("mant", 16'h0096, {2'h0, period_mantissa});
    chk("exp", 16'h0004, {10'h0, period_exponent, period_shift});
    chk("supply", 16'h0013, {8'h0, host_clk_div, slow_clock_out_on, supply_threshold_code});
    chk("afc", 16'h0007, {13'h0, afc_enable, offset_out_enable, precise_measure_mode});
    chk("filt", 16'h0062, {8'h0, auto_lock, lock_speed_select, no_autosleep, filter_kind_select,
        wake_on_any, quality_threshold});
    chk("rate", 16'h0013, {8'h0, rate_prescale, rate_divider});
    chk("offset", 16'h0000, {9'h0, freq_offset});
    chk("wirq", 16'h0000, {15'h0, wake_irq});
  endtask
  task automatic tdone(input string n);
    $display("test %s done", n);
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    end_sim();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {strength_above_threshold, quality_detect, measure_done} = 3'b000;
    clock_lock = 1'b1;
    wake_timer_on = 1'b1;
    measured_error = 7'h00;
    fails = 0;
    checks = 0;
    do_reset();
    chk_def();
    tdone("defaults");
    for (i = 0; i < 4; i++) begin
      cmd(fw[i]);
      chk("freq", fe[i], {4'h0, synth_freq});
    end
    tdone("frequency");
    clock_lock = 1'b0;
    cmd(16'hC0FF);
    chk("rx", 16'h003F, {10'h0, lna_gain, rssi_threshold, rx_enable});
    chk("vflag", 16'h0001, {15'h0, valid_signal_flag});
    for (i = 0; i < 3; i++) begin
      {strength_above_threshold, quality_detect, clock_lock} = 3'b100 >> i;
      cmd(vc[i]);
      chk("vflag", 16'h0001, {15'h0, valid_signal_flag});
      {strength_above_threshold, quality_detect, clock_lock} = 3'b000;
      waitn(6);
      chk("vflag", 16'h0000, {15'h0, valid_signal_flag});
    end
    tdone("receiver");
    cmd(16'hE5AB);
    chk("mant", 16'h00AB, {2'h0, period_mantissa});
    chk("exp", 16'h0014, {10'h0, period_exponent, period_shift});
    cmd(16'hC3E5);
    chk("mant", 16'h25AB, {2'h0, period_mantissa});
    cmd(16'hE7CD);
    chk("mant", 16'h25CD, {2'h0, period_mantissa});
    chk("exp", 16'h001F, {10'h0, period_exponent, period_shift});
    wake_timer_on = 1'b0;
    waitn(6);
    chk("wirq", 16'h0000, {15'h0, wake_irq});
    wake_timer_on = 1'b1;
    tdone("wake");
    cmd(16'hC2AF);
    chk("supply", 16'h00AF, {8'h0, host_clk_div, slow_clock_out_on, supply_threshold_code});
    cmd(16'hC2F0);
    chk("supply", 16'h00F0, {8'h0, host_clk_div, slow_clock_out_on, supply_threshold_code});
    tdone("supply");
    cmd(16'hC603);
    chk("afc", 16'h0006, {13'h0, afc_enable, offset_out_enable, precise_measure_mode});
    meas(7'h05, 1);
    chk("offset", 16'h0000, {9'h0, freq_offset});
    cmd(16'hC60B);
    chk("offset", 16'h0005, {9'h0, freq_offset});
    cmd(16'hC613);
    meas(7'h30, 1);
    cmd(16'hC61B);
    chk("offset", 16'h0004, {9'h0, freq_offset});
    cmd(16'hC633);
    meas(7'h76, 1);
    cmd(16'hC63B);
    chk("offset", 16'h007F, {9'h0, freq_offset});
    cmd(16'hC631);
    chk("offset", 16'h0000, {9'h0, freq_offset});
    tdone("manual");
    cmd(16'hC0C0);
    cmd(16'hC683);
    meas(7'h03, 3);
    chk("offset", 16'h0003, {9'h0, freq_offset});
    cmd(16'hC000);
    chk("offset", 16'h0000, {9'h0, freq_offset});
    cmd(16'hC0C0);
    cmd(16'hC6C3);
    meas(7'h02, 1);
    meas(7'h06, 1);
    chk("offset", 16'h0000, {9'h0, freq_offset});
    meas(7'h06, 1);
    chk("offset", 16'h0006, {9'h0, freq_offset});
    cmd(16'hC000);
    chk("offset", 16'h0006, {9'h0, freq_offset});
    tdone("auto");
    cmd(16'hC4BD);
    chk("filt", 16'h00BD, {8'h0, auto_lock, lock_speed_select, no_autosleep, filter_kind_select,
        wake_on_any, quality_threshold});
    cmd(16'hC442);
    chk("filt", 16'h0042, {8'h0, auto_lock, lock_speed_select, no_autosleep, filter_kind_select,
        wake_on_any, quality_threshold});
    cmd(16'hC8FF);
    chk("rate", 16'h00FF, {8'h0, rate_prescale, rate_divider});
    cmd(16'hC880);
    chk("rate", 16'h0080, {8'h0, rate_prescale, rate_divider});
    tdone("filter_rate");
    cmd(16'h9ABC);
    chk("rate", 16'h0080, {8'h0, rate_prescale, rate_divider});
    chk("freq", 16'h0F3F, {4'h0, synth_freq});
    u_host.send(16'hC801, 8);
    cmd(16'hC805);
    chk("rate", 16'h0005, {8'h0, rate_prescale, rate_divider});
    tdone("refused");
    clock_lock = 1'b1;
    do_reset();
    chk_def();
    tdone("second_reset");
    cmd(16'hC0C0);
    cmd(16'hC643);
    meas(7'h02, 3);
    chk("offset", 16'h0002, {9'h0, freq_offset});
    meas(7'h05, 2);
    chk("offset", 16'h0002, {9'h0, freq_offset});
    tdone("once");
    end_sim();
  end
endmodule
